// File: rtl/uart_flag_pkg.sv
// Constants, carriers and helpers shared by the serial port flag logic.
// Summary of operation
// R1: No FIFO: frame sets full flag; read clears.
// R2: FIFO: fill count sets full; empty clears.
// R3: Idle line eight bits with data sets full.
// R4: Error clear bit clears overrun, framing, parity.
// R5: Parity flag only in normal mode.
// R6: Empty transmit register sets flag; write clears.
// R7: Idle transmitter sets idle flag; write clears.
// R8: Empty FIFO requests; zero write or full clears.
// R9: Software enables transmit interrupt after empty clears.
// R10: Stop bit stores word and sets flags.
// R11: Receive request: enable and any receive flag.
// R12: Software discards words flagged with errors.
// R13: Start edge near stop sample is ignored.
// R14: Start edge polarity follows line inversion.
// R15: Frame arriving while full sets overrun.
// R16: Idle counter restarts on read, held disabled.
// R17: Transmit requests gated by their own enables.
// R18: Requests are levels until flags clear.
package uart_flag_pkg;

  // ----------------------------------------------------------------
  // Sizes and counts
  // ----------------------------------------------------------------
  localparam int DATA_W = 9;
  localparam int FIFO_DEPTH = 128;
  localparam int PTR_W = 7;
  localparam int CNT_W = 8;
  localparam int IDLE_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_FIFO = 8'h80;
  localparam logic [IDLE_W-1:0] IDLE_BITS = 4'h8;
  localparam logic [IDLE_W-1:0] IDLE_LAST = 4'h7;
  localparam logic [IDLE_W-1:0] IDLE_ZERO = 4'h0;
  localparam logic [2:0] LINE_RST = 3'h7;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rx_irq_enable;
    logic tx_irq_enable;
    logic tx_idle_irq_enable;
    logic fifo_tx_irq_enable;
    logic rx_fifo_idle_detect_enable;
    logic rx_fifo_enable;
    logic tx_fifo_enable;
    logic line_invert;
    logic multiproc_mode;
  } ctrl_t;

  typedef struct packed {
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_flag;
    logic parity_flag;
    logic tx_empty_flag;
    logic tx_idle_flag;
    logic fifo_tx_request_flag;
  } status_t;

  localparam status_t STATUS_RST = '{rx_full_flag: 1'b0, overrun_flag: 1'b0,
    framing_flag: 1'b0, parity_flag: 1'b0, tx_empty_flag: 1'b1,
    tx_idle_flag: 1'b1, fifo_tx_request_flag: 1'b0};

  // Without the FIFO a direction holds a single word.
  function automatic logic [CNT_W-1:0] depth_cap(input logic fifo_en);
    depth_cap = fifo_en ? CNT_FIFO : CNT_ONE;
  endfunction

endpackage

// File: rtl/idle_timer.sv
// Receive idle timer that counts bit periods of a quiet line.
`timescale 1ns/100ps
module idle_timer import uart_flag_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic bit_tick,
  // Result
  output logic expired
);

  logic [IDLE_W-1:0] cnt_reg;
  logic [IDLE_W-1:0] cnt_next;

  // Restart wins over counting so a read never lets a stale count fire.
  always_comb begin
    cnt_next = cnt_reg;
    if (restart) begin
      cnt_next = IDLE_ZERO; // R16
    end else if (run && bit_tick && cnt_reg != IDLE_BITS) begin
      cnt_next = cnt_reg + 1'b1; // R3
    end
  end

  assign expired = clk_en && !restart && run && bit_tick && cnt_reg == IDLE_LAST;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_reg <= IDLE_ZERO;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_idle_restart_zero: assert property (clk_en && restart |=> cnt_reg == IDLE_ZERO) // R16
    else $error("idle counter not cleared by restart");
  a_idle_fire_count: assert property (expired |=> cnt_reg == IDLE_BITS) // R3
    else $error("idle expiry without eight bit periods");

endmodule

// File: rtl/uart_flags.sv
// Status flags, interrupt requests and word storage of the serial port.
`timescale 1ns/100ps
module uart_flags import uart_flag_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // Configuration
  input wire ctrl_t ctrl,
  input wire logic [CNT_W-1:0] fifo_fill_count,
  // Software access
  input wire logic rx_read,
  input wire logic rx_error_clear,
  input wire logic tx_write,
  input wire logic [DATA_W-1:0] tx_wdata,
  input wire logic fifo_req_clear,
  output logic [DATA_W-1:0] rx_data,
  output logic [CNT_W-1:0] rx_level,
  output logic [CNT_W-1:0] tx_level,
  output status_t status,
  output logic rx_irq,
  output logic tx_irq,
  // Serial line
  input wire logic rx_pin,
  output logic start_edge,
  // Receive engine
  input wire logic stop_window,
  input wire logic bit_tick,
  input wire logic frame_done,
  input wire logic [DATA_W-1:0] frame_word,
  input wire logic frame_bad_stop,
  input wire logic frame_bad_parity,
  // Transmit engine
  input wire logic tx_take,
  input wire logic tx_sending,
  output logic [DATA_W-1:0] tx_word,
  output logic tx_avail
);

  // ----------------------------------------------------------------
  // Line synchroniser and start edge
  // ----------------------------------------------------------------
  logic [2:0] line_reg;
  logic [2:0] line_next;
  logic start_reg;
  logic start_next;
  logic norm_now;
  logic norm_prev;
  logic line_idle;

  // Bit 0 is read only by bit 1; the edge test uses bits 1 and 2.
  assign norm_now = line_reg[1] ^ ctrl.line_invert;
  assign norm_prev = line_reg[2] ^ ctrl.line_invert;
  assign line_idle = norm_now;

  always_comb begin
    line_next = {line_reg[1], line_reg[0], rx_pin};
    start_next = norm_prev && !norm_now && !stop_window; // R14 R13
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      line_reg <= LINE_RST;
      start_reg <= 1'b0;
    end else if (clk_en) begin
      line_reg <= line_next;
      start_reg <= start_next;
    end
  end

  assign start_edge = start_reg;

  // ----------------------------------------------------------------
  // Receive storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] rx_wr_reg;
  logic [PTR_W-1:0] rx_wr_next;
  logic [PTR_W-1:0] rx_rd_reg;
  logic [PTR_W-1:0] rx_rd_next;
  logic [CNT_W-1:0] rx_cnt_reg;
  logic [CNT_W-1:0] rx_cnt_next;
  logic rx_pop;
  logic rx_room;
  logic rx_store;

  // A word is dropped, not overwritten, when storage has no room.
  assign rx_pop = rx_read && rx_cnt_reg != CNT_ZERO;
  assign rx_room = rx_cnt_reg < depth_cap(ctrl.rx_fifo_enable) || rx_pop;
  assign rx_store = frame_done && rx_room; // R10

  always_comb begin
    rx_wr_next = rx_wr_reg;
    rx_rd_next = rx_rd_reg;
    rx_cnt_next = rx_cnt_reg;
    if (rx_store) begin
      rx_wr_next = rx_wr_reg + 1'b1;
    end
    if (rx_pop) begin
      rx_rd_next = rx_rd_reg + 1'b1;
    end
    if (rx_store && !rx_pop) begin
      rx_cnt_next = rx_cnt_reg + CNT_ONE;
    end else if (!rx_store && rx_pop) begin
      rx_cnt_next = rx_cnt_reg - CNT_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
      rx_cnt_reg <= CNT_ZERO;
    end else if (clk_en) begin
      rx_wr_reg <= rx_wr_next;
      rx_rd_reg <= rx_rd_next;
      rx_cnt_reg <= rx_cnt_next;
      if (rx_store) begin
        rx_mem[rx_wr_reg] <= frame_word;
      end
    end
  end

  assign rx_data = rx_mem[rx_rd_reg];
  assign rx_level = rx_cnt_reg;

  // ----------------------------------------------------------------
  // Receive idle detection
  // ----------------------------------------------------------------
  logic idle_run;
  logic idle_restart;
  logic idle_expired;

  assign idle_run = ctrl.rx_fifo_idle_detect_enable && ctrl.rx_fifo_enable && line_idle
    && rx_cnt_reg != CNT_ZERO && rx_cnt_reg < fifo_fill_count; // R3
  assign idle_restart = rx_read || !ctrl.rx_fifo_enable || !line_idle; // R16

  idle_timer i_idle_timer (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .run(idle_run),
    .restart(idle_restart),
    .bit_tick(bit_tick),
    .expired(idle_expired)
  );

  // ----------------------------------------------------------------
  // Transmit storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] tx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] tx_wr_reg;
  logic [PTR_W-1:0] tx_wr_next;
  logic [PTR_W-1:0] tx_rd_reg;
  logic [PTR_W-1:0] tx_rd_next;
  logic [CNT_W-1:0] tx_cnt_reg;
  logic [CNT_W-1:0] tx_cnt_next;
  logic tx_fen_reg;
  logic tx_push;
  logic tx_pop;
  logic tx_drained;
  logic tx_resend;

  assign tx_push = tx_write && tx_cnt_reg < depth_cap(ctrl.tx_fifo_enable);
  assign tx_pop = tx_take && tx_cnt_reg != CNT_ZERO;
  assign tx_drained = tx_pop && !tx_push && tx_cnt_reg == CNT_ONE;
  // Turning the FIFO back on with words left in it clears the empty and idle flags.
  assign tx_resend = ctrl.tx_fifo_enable && !tx_fen_reg && tx_cnt_reg != CNT_ZERO;

  always_comb begin
    tx_wr_next = tx_wr_reg;
    tx_rd_next = tx_rd_reg;
    tx_cnt_next = tx_cnt_reg;
    if (tx_push) begin
      tx_wr_next = tx_wr_reg + 1'b1;
    end
    if (tx_pop) begin
      tx_rd_next = tx_rd_reg + 1'b1;
    end
    if (tx_push && !tx_pop) begin
      tx_cnt_next = tx_cnt_reg + CNT_ONE;
    end else if (!tx_push && tx_pop) begin
      tx_cnt_next = tx_cnt_reg - CNT_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
      tx_cnt_reg <= CNT_ZERO;
      tx_fen_reg <= 1'b0;
    end else if (clk_en) begin
      tx_wr_reg <= tx_wr_next;
      tx_rd_reg <= tx_rd_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_fen_reg <= ctrl.tx_fifo_enable;
      if (tx_push) begin
        tx_mem[tx_wr_reg] <= tx_wdata;
      end
    end
  end

  assign tx_word = tx_mem[tx_rd_reg];
  assign tx_avail = tx_cnt_reg != CNT_ZERO;
  assign tx_level = tx_cnt_reg;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  status_t status_reg;
  status_t status_next;
  logic full_set;
  logic full_clr;
  logic txe_clr;
  logic fifo_tx_request_flag_set;
  logic fifo_tx_request_flag_clr;

  always_comb begin
    // Hardware events win over a clear in the same cycle, except the transmit idle condition, which a write beats.
    if (ctrl.rx_fifo_enable) begin
      full_set = (rx_store && rx_cnt_next == fifo_fill_count) || idle_expired; // R2 R3
      full_clr = rx_pop && rx_cnt_next == CNT_ZERO; // R2
    end else begin
      full_set = rx_store; // R1
      full_clr = rx_pop; // R1
    end
    txe_clr = tx_write || tx_resend; // R6
    fifo_tx_request_flag_set = ctrl.tx_fifo_enable && (tx_drained || (!tx_fen_reg && !tx_avail)); // R8
    fifo_tx_request_flag_clr = fifo_req_clear
      || (ctrl.tx_fifo_enable && tx_cnt_next >= CNT_FIFO); // R8
    status_next = status_reg;
    status_next.rx_full_flag = full_set || (status_reg.rx_full_flag && !full_clr);
    status_next.overrun_flag = (frame_done && !rx_room) // R15
      || (status_reg.overrun_flag && !rx_error_clear); // R4
    status_next.framing_flag = (frame_done && frame_bad_stop) // R10
      || (status_reg.framing_flag && !rx_error_clear); // R4
    status_next.parity_flag = (frame_done && frame_bad_parity && !ctrl.multiproc_mode) // R5
      || (status_reg.parity_flag && !rx_error_clear); // R4
    status_next.tx_empty_flag = tx_drained || (status_reg.tx_empty_flag && !txe_clr); // R6
    // The idle condition is a level, so a write must be allowed to beat it.
    status_next.tx_idle_flag = !txe_clr
      && (status_reg.tx_idle_flag || (status_reg.tx_empty_flag && !tx_sending)); // R7
    status_next.fifo_tx_request_flag = fifo_tx_request_flag_set
      || (status_reg.fifo_tx_request_flag && !fifo_tx_request_flag_clr);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      status_reg <= STATUS_RST;
    end else if (clk_en) begin
      status_reg <= status_next;
    end
  end

  assign status = status_reg;

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  assign rx_irq = ctrl.rx_irq_enable && (status_reg.rx_full_flag || status_reg.overrun_flag
    || status_reg.framing_flag || status_reg.parity_flag); // R11 R18
  assign tx_irq = (ctrl.tx_irq_enable && status_reg.tx_empty_flag)
    || (ctrl.tx_idle_irq_enable && status_reg.tx_idle_flag)
    || (ctrl.fifo_tx_irq_enable && status_reg.fifo_tx_request_flag); // R17 R18

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_frame_in;
    clk_en && frame_done;
  endsequence

  // The request follows the flag in the same cycle, so a read one cycle later is legal.
  sequence s_flag_raised;
    ##1 status.rx_full_flag ##0 (rx_irq || !ctrl.rx_irq_enable);
  endsequence

  a_single_full_set: assert property (s_frame_in ##0 (!ctrl.rx_fifo_enable // R1
    && rx_cnt_reg == CNT_ZERO) |-> s_flag_raised)
    else $error("single word receive did not raise full flag");
  a_single_read_clr: assert property (clk_en && !ctrl.rx_fifo_enable && rx_read // R1
    && !frame_done && rx_cnt_reg == CNT_ONE |=> !status.rx_full_flag && rx_level == CNT_ZERO)
    else $error("read did not clear single word full flag");
  a_fifo_fill_set: assert property (s_frame_in ##0 (ctrl.rx_fifo_enable && !rx_read // R2
    && rx_cnt_reg < CNT_FIFO && rx_cnt_reg + CNT_ONE == fifo_fill_count)
    |=> status.rx_full_flag)
    else $error("fill count reached without full flag");
  a_err_clear_all: assert property (clk_en && rx_error_clear && !frame_done // R4
    |=> !status.overrun_flag && !status.framing_flag && !status.parity_flag)
    else $error("error clear left an error flag set");
  a_parity_multiproc: assert property (clk_en && ctrl.multiproc_mode && !status.parity_flag // R5
    |=> !status.parity_flag)
    else $error("parity flag raised in multiprocessor mode");
  a_tx_write_clear: assert property (clk_en && tx_write && !tx_take // R6 R7
    |=> !status.tx_empty_flag ##1 (status.tx_idle_flag == 1'b0 || !clk_en || tx_write))
    else $error("transmit write did not clear flags");
  a_fifo_tx_request_flag_full_clr: assert property (clk_en && ctrl.tx_fifo_enable && tx_write && !tx_take // R8
    && tx_cnt_reg == CNT_FIFO - CNT_ONE |=> !status.fifo_tx_request_flag)
    else $error("request flag stayed set at full FIFO");
  a_overrun_full: assert property (s_frame_in ##0 (!ctrl.rx_fifo_enable && !rx_read // R15
    && status.rx_full_flag) |=> status.overrun_flag && $stable(rx_level))
    else $error("frame into full register without overrun");
  a_start_masked: assert property (clk_en && stop_window |=> !start_edge) // R13
    else $error("start edge accepted near stop sample");
  a_tx_irq_gate: assert property (!ctrl.tx_irq_enable && !ctrl.tx_idle_irq_enable // R17
    && !ctrl.fifo_tx_irq_enable |-> !tx_irq)
    else $error("transmit request with all enables off");
  // The enable is looked at in the cycle of the check, since software may drop it any time.
  a_rx_irq_hold: assert property ((rx_irq && clk_en && !rx_error_clear && !rx_read) // R18
    ##1 ctrl.rx_irq_enable |-> rx_irq)
    else $error("receive request dropped without a clear");

endmodule

// File: dv/line_peer.sv
// Model of the remote serial station together with its frame engines.
`timescale 1ns/100ps
module line_peer import uart_flag_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Requests from the bench
  input wire logic go,
  input wire logic late,
  input wire logic stall,
  input wire logic line_invert,
  input wire logic [DATA_W+1:0] frame,
  output logic busy,
  // Receive engine side
  output logic rx_pin,
  output logic stop_window,
  output logic bit_tick,
  output logic frame_done,
  output logic [DATA_W-1:0] frame_word,
  output logic frame_bad_stop,
  output logic frame_bad_parity,
  // Transmit engine side
  input wire logic tx_avail,
  output logic tx_take,
  output logic tx_sending
);
  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  logic [3:0] t;
  logic [3:0] s;
  logic [1:0] b;
  assign busy = (t != 4'h0);
  always_ff @(posedge mclk) begin
    b <= b + 2'h1;
    bit_tick <= (b == 2'h3);
    frame_done <= (t == 4'hd);
    // Frame fields mean nothing between strobes, so they wander there.
    {frame_bad_parity, frame_bad_stop, frame_word} <= (t == 4'hd) ? frame :
      ~{frame_bad_parity, frame_bad_stop, frame_word};
    // A late start lands in the stop window; normally the gap is ample.
    stop_window <= (t >= 4'hb && t <= 4'hd) || (late && t >= 4'h1 && t <= 4'h3);
    t <= (t == 4'he) ? 4'h0 : (t != 4'h0 || go) ? t + 4'h1 : t;
    rx_pin <= ((t == 4'h0 && !go) || t >= 4'ha) ? ~line_invert : line_invert;
    tx_take <= 1'b0;
    if (tx_sending) begin
      s <= s - 4'h1;
      tx_sending <= (s != 4'h1);
    end else if (tx_avail && !stall) begin
      tx_take <= 1'b1;
      tx_sending <= 1'b1;
      s <= 4'h8;
    end
    if (reset) begin
      t <= 4'h0;
      b <= 2'h0;
      tx_sending <= 1'b0;
      tx_take <= 1'b0;
      {frame_bad_parity, frame_bad_stop, frame_word} <= '0;
    end
  end
endmodule

// File: dv/test_uart_interrupt_flag_logic.sv
// Self-checking bench for the serial port flag and request logic.
`timescale 1ns/100ps
module test_uart_interrupt_flag_logic import uart_flag_pkg::*; ;
  typedef struct packed {
    status_t st;
    logic [CNT_W-1:0] rl;
    logic [CNT_W-1:0] tl;
    logic [1:0] irq;
    logic [7:0] edges;
  } note_t;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  ctrl_t ctrl = '0;
  logic [CNT_W-1:0] fifo_fill_count = 8'h01;
  logic rx_read = 1'b0, rx_error_clear = 1'b0, tx_write = 1'b0, fifo_req_clear = 1'b0;
  logic [DATA_W-1:0] tx_wdata = '0, rx_data, tx_word, frame_word, w0;
  logic [CNT_W-1:0] rx_level, tx_level, erl = '0, etl = '0;
  status_t status, es;
  logic rx_irq, tx_irq, rx_pin, start_edge, stop_window, bit_tick, frame_done;
  logic frame_bad_stop, frame_bad_parity, tx_take, tx_sending, tx_avail, busy;
  logic go = 1'b0, late = 1'b0, stall = 1'b1, look = 1'b0;
  logic [DATA_W+1:0] frame = '0;
  logic [7:0] edges = '0, ee = '0;
  note_t q[$];
  logic [DATA_W-1:0] rxq[$], txq[$];
  int errors = 0, checked = 0, cyc = 0, i;

  always #5 mclk = ~mclk;
  uart_flags i_uart_flags (.mclk, .reset, .clk_en, .ctrl, .fifo_fill_count, .rx_read,
    .rx_error_clear, .tx_write, .tx_wdata, .fifo_req_clear, .rx_data, .rx_level, .tx_level,
    .status, .rx_irq, .tx_irq, .rx_pin, .start_edge, .stop_window, .bit_tick, .frame_done,
    .frame_word, .frame_bad_stop, .frame_bad_parity, .tx_take, .tx_sending, .tx_word,
    .tx_avail);
  line_peer i_line_peer (.mclk, .reset, .go, .late, .stall, .line_invert(ctrl.line_invert),
    .frame, .busy, .rx_pin, .stop_window, .bit_tick, .frame_done, .frame_word, .frame_bad_stop,
    .frame_bad_parity, .tx_avail, .tx_take, .tx_sending);

  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task automatic check(string what, logic [32:0] seen, logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(negedge mclk) begin
    if (look) check("flags", {status, rx_level, tx_level, rx_irq, tx_irq, edges}, q.pop_front());
  end

  always @(posedge mclk) begin
    cyc++;
    if (start_edge === 1'b1) edges <= edges + 8'h01;
    if (tx_take === 1'b1) check("tx_word", tx_word, txq.pop_front());
    if (rx_read === 1'b1 && clk_en === 1'b1 && rx_level != '0)
      check("rx_data", rx_data, rxq.pop_front());
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic note();
    @(posedge mclk);
    q.push_back({es, erl, etl, ctrl.rx_irq_enable && (es.rx_full_flag || es.overrun_flag
      || es.framing_flag || es.parity_flag),
      (ctrl.tx_irq_enable && es.tx_empty_flag) || (ctrl.tx_idle_irq_enable && es.tx_idle_flag)
      || (ctrl.fifo_tx_irq_enable && es.fifo_tx_request_flag), ee});
    look <= 1'b1;
    @(posedge mclk);
    look <= 1'b0;
  endtask

  task automatic send(logic [DATA_W-1:0] w, logic bs, logic bp, logic keep, logic lt);
    frame <= {bp, bs, w};
    late <= lt;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    for (int k = 0; k < 40 && busy; k++) @(posedge mclk);
    if (keep) rxq.push_back(w);
    if (!lt) ee++;
  endtask

  task automatic rd(int n);
    rx_read <= 1'b1;
    repeat (n) @(posedge mclk);
    rx_read <= 1'b0;
  endtask

  task automatic wr(int n, int keep);
    logic [DATA_W-1:0] w;
    tx_write <= 1'b1;
    repeat (n) begin
      w = DATA_W'($urandom);
      tx_wdata <= w;
      if (keep-- > 0) txq.push_back(w);
      @(posedge mclk);
    end
    tx_write <= 1'b0;
  endtask

  task automatic clr(logic e, logic f);
    rx_error_clear <= e;
    fifo_req_clear <= f;
    @(posedge mclk);
    rx_error_clear <= 1'b0;
    fifo_req_clear <= 1'b0;
  endtask

  task automatic drain();
    stall <= 1'b0;
    for (int k = 0; k < 2000 && status.tx_idle_flag !== 1'b1; k++) @(posedge mclk);
    stall <= 1'b1;
  endtask

  initial begin
    void'($urandom(32'he9e5_4729));
    ctrl.rx_irq_enable <= 1'b1;
    ctrl.tx_idle_irq_enable <= 1'b1;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    es = STATUS_RST;
    note();
    // A second write without the FIFO finds the single slot taken.
    wr(2, 1);
    es.tx_empty_flag = 1'b0;
    es.tx_idle_flag = 1'b0;
    etl = 8'h01;
    note();
    ctrl.tx_irq_enable <= 1'b1;
    note();
    drain();
    es = STATUS_RST;
    etl = '0;
    note();
    w0 = DATA_W'($urandom);
    send(w0, 1'b0, 1'b0, 1'b1, 1'b0);
    es.rx_full_flag = 1'b1;
    erl = 8'h01;
    note();
    send(~w0, 1'b0, 1'b0, 1'b0, 1'b0);
    es.overrun_flag = 1'b1;
    note();
    // A read while the clock enable is low must leave every flag and level alone.
    clk_en <= 1'b0;
    rd(1);
    clk_en <= 1'b1;
    note();
    rd(1);
    es.rx_full_flag = 1'b0;
    erl = '0;
    note();
    clr(1'b1, 1'b0);
    es.overrun_flag = 1'b0;
    ctrl.line_invert <= 1'b1;
    note();
    send(DATA_W'($urandom), 1'b1, 1'b1, 1'b1, 1'b0);
    es.rx_full_flag = 1'b1;
    es.framing_flag = 1'b1;
    es.parity_flag = 1'b1;
    erl = 8'h01;
    note();
    rd(1);
    clr(1'b1, 1'b0);
    ctrl.multiproc_mode <= 1'b1;
    send(DATA_W'($urandom), 1'b0, 1'b1, 1'b1, 1'b0);
    es = STATUS_RST;
    es.rx_full_flag = 1'b1;
    note();
    rd(1);
    send(DATA_W'($urandom), 1'b0, 1'b0, 1'b1, 1'b1);
    note();
    rd(1);
    ctrl.line_invert <= 1'b0;
    ctrl.multiproc_mode <= 1'b0;
    ctrl.rx_fifo_enable <= 1'b1;
    fifo_fill_count <= 8'h03;
    es.rx_full_flag = 1'b0;
    erl = '0;
    // The line must rest at its new idle level before the next start bit.
    repeat (4) @(posedge mclk);
    for (i = 1; i <= 3; i++) begin
      send(DATA_W'($urandom), 1'b0, 1'b0, 1'b1, 1'b0);
      erl = erl + 8'h01;
      es.rx_full_flag = (i == 3);
      note();
    end
    rd(2);
    erl = 8'h01;
    note();
    rd(1);
    es.rx_full_flag = 1'b0;
    erl = '0;
    fifo_fill_count <= 8'h04;
    ctrl.rx_fifo_idle_detect_enable <= 1'b1;
    note();
    send(DATA_W'($urandom), 1'b0, 1'b0, 1'b1, 1'b0);
    send(DATA_W'($urandom), 1'b0, 1'b0, 1'b1, 1'b0);
    erl = 8'h02;
    repeat (20) @(posedge mclk);
    rd(1);
    erl = 8'h01;
    repeat (16) @(posedge mclk);
    note();
    repeat (24) @(posedge mclk);
    es.rx_full_flag = 1'b1;
    note();
    rd(1);
    es.rx_full_flag = 1'b0;
    erl = '0;
    ctrl.tx_fifo_enable <= 1'b1;
    ctrl.fifo_tx_irq_enable <= 1'b1;
    es.fifo_tx_request_flag = 1'b1;
    note();
    // Fill past capacity while the far side stalls.
    wr(129, 128);
    es.fifo_tx_request_flag = 1'b0;
    es.tx_empty_flag = 1'b0;
    es.tx_idle_flag = 1'b0;
    etl = CNT_FIFO;
    note();
    drain();
    es = STATUS_RST;
    es.fifo_tx_request_flag = 1'b1;
    etl = '0;
    note();
    clr(1'b0, 1'b1);
    es.fifo_tx_request_flag = 1'b0;
    note();
    tally_and_finish();
  end
endmodule
